// ---- sd_clock_pkg.sv ----
// Shared constants and carrier types for the card clock and power control block.
// Assumes a 16-bit asynchronous host port with byte addresses and a 20 MHz core clock.
package sd_clock_pkg;

  // Register offsets, byte addresses of 16-bit words
  localparam logic [7:0] CLK_CTRL_OFS   = 8'h2C;
  localparam logic [7:0] SOFT_RESET_OFS = 8'h2E;
  localparam logic [7:0] FRAC_OFS       = 8'hF6;
  localparam logic [7:0] MISC_OFS       = 8'hF8;
  localparam logic [7:0] PLL_OFS        = 8'hFA;
  localparam logic [7:0] REV_OFS        = 8'hFE;

  // Clock control fields
  localparam int CLK_INT_EN_BIT  = 0;
  localparam int CLK_STABLE_BIT  = 1;
  localparam int CLK_CARD_EN_BIT = 2;
  localparam int CLK_DIV_LSB     = 8;
  localparam int CLK_DIV_MSB     = 15;
  // Software reset word: reset-for-all sits in the upper byte
  localparam int SOFT_RESET_ALL_BIT = 8;
  // Fractional divider fields
  localparam int FRAC_N_LSB = 0;
  localparam int FRAC_N_MSB = 7;
  localparam int FRAC_M_LSB = 8;
  localparam int FRAC_M_MSB = 11;
  // Miscellaneous fields
  localparam int MISC_COMA_BIT     = 0;
  localparam int MISC_DMA_EN_BIT   = 1;
  localparam int MISC_INT_MODE_BIT = 2;
  // PLL fields
  localparam int PLL_B_LSB          = 0;
  localparam int PLL_B_MSB          = 4;
  localparam int PLL_P_LSB          = 5;
  localparam int PLL_P_MSB          = 6;
  localparam int PLL_BYP_POST_BIT   = 14;
  localparam int PLL_BYP_ALL_BIT    = 15;

  // Reset values
  localparam logic [15:0] CLK_CTRL_RESET = 16'h0000;
  localparam logic [15:0] FRAC_RESET     = 16'h0001;
  localparam logic [15:0] MISC_RESET     = 16'h0002;
  localparam logic [15:0] PLL_RESET      = 16'h0024;
  localparam logic [5:0]  PLL_RESET_MULT = 6'h05;
  localparam logic [1:0]  POST_BYPASS_P  = 2'h1;
  localparam logic [5:0]  MULT_BYPASS    = 6'h01;

  // Divider arithmetic: steps per toggle in sixteenths, two toggles per period
  localparam int          STEP_SHIFT   = 5;
  localparam logic [20:0] TOTAL_RESET  = 21'h000010;
  localparam logic [10:0] STEP_RESET   = 11'h0A0;

  // Power state
  typedef enum logic {
    PWR_ON   = 1'b0,
    PWR_COMA = 1'b1
  } power_state_t;

  // Host pin sample, active-high strobes
  typedef struct packed {
    logic        cs;
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] data;
  } host_access_t;

endpackage : sd_clock_pkg

// ---- card_clock_divider.sv ----
// Fractional card clock generator driven by the multiplied reference rate.
// Assumes run and settings come from the same clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module card_clock_divider (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [7:0] divisor_sel,
  input  wire logic [7:0] frac_n,
  input  wire logic [3:0] frac_m,
  input  wire logic [5:0] multiplier,
  output logic            card_clock_out
);

  logic [20:0] acc_reg;
  logic [20:0] total_reg;
  logic [10:0] step_reg;
  logic [21:0] sum;
  logic        wrap;

  // Period in sixteenths of a source cycle: divisor times (16N + M)
  function automatic logic [20:0] period_units(input logic [7:0] sel, input logic [7:0] n,
                                               input logic [3:0] m);
    logic [8:0] divisor;
    divisor = (sel == 8'h00) ? 9'h001 : {sel, 1'b0};
    period_units = 21'(divisor * {n, m}); // [RULE1]
  endfunction : period_units

  // Phase accumulator: toggle whenever a half period has accrued
  assign sum  = {1'b0, acc_reg} + {11'h000, step_reg};
  assign wrap = (sum >= {1'b0, total_reg});

  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      acc_reg <= 21'h000000;
    end else if (wrap) begin
      acc_reg <= 21'(sum - {1'b0, total_reg}); // [RULE1]
    end else begin
      acc_reg <= sum[20:0];
    end
  end

  // Clock output; held low while stopped
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      card_clock_out <= 1'b0;
    end else if (wrap) begin
      card_clock_out <= ~card_clock_out;
    end
  end

  // New settings load while stopped or at a falling edge, so no phase is cut short
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      total_reg <= sd_clock_pkg::TOTAL_RESET;
      step_reg  <= sd_clock_pkg::STEP_RESET;
    end else if (!run || (wrap && card_clock_out)) begin // [RULE13]
      total_reg <= period_units(divisor_sel, frac_n, frac_m); // [RULE1]
      step_reg  <= {multiplier, 5'h00}; // [RULE9]
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  settings_at_fall_a: assert property ($changed(total_reg) && $past(run) |-> // [RULE13]
    $fell(card_clock_out)) else $error("divider settings changed mid-phase");
  toggle_on_wrap_a: assert property (run && wrap |=> $past(run) && // [RULE1]
    card_clock_out != $past(card_clock_out)) else $error("missed card clock toggle");

endmodule : card_clock_divider
`default_nettype wire

// ---- sd_clock_power_ctrl.sv ----
// Card clock, PLL setting and power/pin control registers behind the async host port.
// Assumes host strobes are held at least three clk cycles and data is stable meanwhile.
// How it works
// [RULE1] Card clock equals PLL rate over divisor times (N plus M/16).
// [RULE2] Fractional register: N in bits 7:0, M in 11:8, 15:12 reserved.
// [RULE3] Misc bit 2, reset 0: interrupt pin open-drain at 0, push-pull at 1.
// [RULE4] Misc bit 1, reset 1: DMA request passes at 1, held low at 0.
// [RULE5] Misc bit 0 set: power off, state lost, only full reset accepted.
// [RULE6] Leaving power-off: software full-reset write or the hard reset pin.
// [RULE7] PLL register reset values multiply the reference by five.
// [RULE8] PLL multiplier is feedback field B in bits 4:0 plus one.
// [RULE9] Post divider P in bits 6:5 changes duty only, never frequency.
// [RULE10] Software keeps 2(P+1) times PLL rate between 156 and 320 MHz.
// [RULE11] One bit bypasses the post divider as P=1, another the whole PLL.
// [RULE12] Version register returns its code in bits 15:8, low byte reserved.
// [RULE13] Divider or PLL changes reach the card clock without short phases.
`timescale 1ns/100ps
`default_nettype none
module sd_clock_power_ctrl #(
  parameter logic [7:0] REVISION_CODE = 8'hA5 // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        cs_b,
  input  wire logic        rd_b,
  input  wire logic        wr_b,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out,
  output logic             data_oe,
  input  wire logic        int_request,
  output logic             int_out,
  output logic             int_oe,
  input  wire logic        dma_request_in,
  output logic             dma_request_out,
  output logic             card_clock_out,
  output logic      [5:0]  pll_multiplier,
  output logic      [1:0]  pll_post_div,
  output logic             pll_bypassed,
  output logic             core_power_on
);

  logic                       rst_meta_reg;
  logic                       rst_n;
  sd_clock_pkg::host_access_t pin_meta_reg;
  sd_clock_pkg::host_access_t pin_sync_reg;
  logic                       wr_prev_reg;
  logic                       write_pulse;
  logic                       write_ok;
  logic                       soft_reset_hit;
  logic                       clear_regs;
  logic                       powered;
  logic                       read_active;
  sd_clock_pkg::power_state_t power_state_reg;
  logic [15:0]                clk_ctrl_reg;
  logic [15:0]                frac_reg;
  logic [15:0]                misc_reg;
  logic [15:0]                pll_reg;
  logic                       card_run;

  // Release of the hard reset through two flip-flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Host pins pass two flip-flops; strobes turned active high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= '{cs: ~cs_b, rd: ~rd_b, wr: ~wr_b, addr: addr, data: data_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Write strobe edge detector on the synchronised copy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_prev_reg <= 1'b0;
    end else begin
      wr_prev_reg <= pin_sync_reg.cs & pin_sync_reg.wr;
    end
  end

  // Address match, shared by write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:1] == ofs[7:1]);
  endfunction : hit

  // Read mux of all mapped words but the soft reset word; it and unmapped reads give zero
  function automatic logic [15:0] read_word(input logic [7:0] a, input logic [15:0] cc,
                                            input logic [15:0] fr, input logic [15:0] mi,
                                            input logic [15:0] pl, input logic [7:0] rev);
    read_word = 16'h0000;
    if (hit(a, sd_clock_pkg::CLK_CTRL_OFS)) begin
      read_word = cc;
    end else if (hit(a, sd_clock_pkg::FRAC_OFS)) begin
      read_word = fr;
    end else if (hit(a, sd_clock_pkg::MISC_OFS)) begin
      read_word = mi;
    end else if (hit(a, sd_clock_pkg::PLL_OFS)) begin
      read_word = pl;
    end else if (hit(a, sd_clock_pkg::REV_OFS)) begin
      read_word = {rev, 8'h00}; // [RULE12]
    end
  endfunction : read_word

  // Access qualification: in power-off only the full-reset bit is heard
  assign write_pulse    = pin_sync_reg.cs & pin_sync_reg.wr & ~wr_prev_reg;
  assign soft_reset_hit = write_pulse && hit(pin_sync_reg.addr, sd_clock_pkg::SOFT_RESET_OFS)
                          && pin_sync_reg.data[sd_clock_pkg::SOFT_RESET_ALL_BIT]; // [RULE6]
  assign powered        = (power_state_reg == sd_clock_pkg::PWR_ON);
  assign write_ok       = write_pulse & powered; // [RULE5]
  assign clear_regs     = soft_reset_hit | ~powered; // [RULE5]
  assign read_active    = pin_sync_reg.cs & pin_sync_reg.rd & powered; // [RULE5]

  // Power state: enter on the coma bit, leave on full reset or the pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_state_reg <= sd_clock_pkg::PWR_ON; // [RULE6]
    end else begin
      unique case (power_state_reg)
        sd_clock_pkg::PWR_ON: begin
          if (write_ok && hit(pin_sync_reg.addr, sd_clock_pkg::MISC_OFS)
              && pin_sync_reg.data[sd_clock_pkg::MISC_COMA_BIT] && !soft_reset_hit) begin
            power_state_reg <= sd_clock_pkg::PWR_COMA; // [RULE5]
          end
        end
        sd_clock_pkg::PWR_COMA: begin
          if (soft_reset_hit) begin
            power_state_reg <= sd_clock_pkg::PWR_ON; // [RULE6]
          end
        end
      endcase
    end
  end

  // Clock control: divisor byte, card enable, internal enable; stable mirrors enable
  always_ff @(posedge clk) begin
    if (!rst_n || clear_regs) begin
      clk_ctrl_reg <= sd_clock_pkg::CLK_CTRL_RESET;
    end else if (write_ok && hit(pin_sync_reg.addr, sd_clock_pkg::CLK_CTRL_OFS)) begin
      clk_ctrl_reg <= {pin_sync_reg.data[sd_clock_pkg::CLK_DIV_MSB:sd_clock_pkg::CLK_DIV_LSB],
                       5'h00, pin_sync_reg.data[sd_clock_pkg::CLK_CARD_EN_BIT],
                       pin_sync_reg.data[sd_clock_pkg::CLK_INT_EN_BIT],
                       pin_sync_reg.data[sd_clock_pkg::CLK_INT_EN_BIT]};
    end
  end

  // Fractional divider: reserved top nibble reads zero
  always_ff @(posedge clk) begin
    if (!rst_n || clear_regs) begin
      frac_reg <= sd_clock_pkg::FRAC_RESET;
    end else if (write_ok && hit(pin_sync_reg.addr, sd_clock_pkg::FRAC_OFS)) begin
      frac_reg <= {4'h0, pin_sync_reg.data[sd_clock_pkg::FRAC_M_MSB:sd_clock_pkg::FRAC_N_LSB]}; // [RULE2]
    end
  end

  // Miscellaneous: interrupt mode and DMA enable kept, coma bit held in the state
  always_ff @(posedge clk) begin
    if (!rst_n || clear_regs) begin
      misc_reg <= sd_clock_pkg::MISC_RESET; // [RULE3] [RULE4]
    end else if (write_ok && hit(pin_sync_reg.addr, sd_clock_pkg::MISC_OFS)) begin
      misc_reg <= {13'h0000, pin_sync_reg.data[sd_clock_pkg::MISC_INT_MODE_BIT],
                   pin_sync_reg.data[sd_clock_pkg::MISC_DMA_EN_BIT], 1'b0};
    end
  end

  // PLL: bypass bits, post divider and feedback divider; middle bits read zero
  always_ff @(posedge clk) begin
    if (!rst_n || clear_regs) begin
      pll_reg <= sd_clock_pkg::PLL_RESET; // [RULE7]
    end else if (write_ok && hit(pin_sync_reg.addr, sd_clock_pkg::PLL_OFS)) begin
      pll_reg <= {pin_sync_reg.data[sd_clock_pkg::PLL_BYP_ALL_BIT:sd_clock_pkg::PLL_BYP_POST_BIT],
                  7'h00, pin_sync_reg.data[sd_clock_pkg::PLL_P_MSB:sd_clock_pkg::PLL_B_LSB]}; // [RULE11]
    end
  end

  // Effective PLL settings
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pll_multiplier <= sd_clock_pkg::PLL_RESET_MULT;
      pll_post_div   <= sd_clock_pkg::PLL_RESET[sd_clock_pkg::PLL_P_MSB:sd_clock_pkg::PLL_P_LSB];
      pll_bypassed   <= 1'b0;
    end else begin
      pll_multiplier <= pll_reg[sd_clock_pkg::PLL_BYP_ALL_BIT] ? sd_clock_pkg::MULT_BYPASS // [RULE11]
                        : {1'b0, pll_reg[sd_clock_pkg::PLL_B_MSB:sd_clock_pkg::PLL_B_LSB]} + 6'h01; // [RULE8]
      pll_post_div   <= pll_reg[sd_clock_pkg::PLL_BYP_POST_BIT] ? sd_clock_pkg::POST_BYPASS_P // [RULE11]
                        : pll_reg[sd_clock_pkg::PLL_P_MSB:sd_clock_pkg::PLL_P_LSB];
      pll_bypassed   <= pll_reg[sd_clock_pkg::PLL_BYP_ALL_BIT];
    end
  end

  // Read data captured while the read strobe is held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_out <= 16'h0000;
    end else if (read_active) begin
      data_out <= read_word(pin_sync_reg.addr, clk_ctrl_reg, frac_reg, misc_reg, pll_reg,
                            REVISION_CODE);
    end
  end

  assign data_oe       = read_active;
  assign core_power_on = powered;

  // Interrupt pin driver; released entirely while powered off
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_out <= 1'b0;
      int_oe  <= 1'b0;
    end else if (misc_reg[sd_clock_pkg::MISC_INT_MODE_BIT]) begin
      int_out <= ~int_request; // [RULE3]
      int_oe  <= powered;
    end else begin
      int_out <= 1'b0; // [RULE3]
      int_oe  <= int_request & powered;
    end
  end

  // DMA request gate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dma_request_out <= 1'b0;
    end else begin
      dma_request_out <= dma_request_in & misc_reg[sd_clock_pkg::MISC_DMA_EN_BIT] & powered; // [RULE4]
    end
  end

  assign card_run = powered & clk_ctrl_reg[sd_clock_pkg::CLK_INT_EN_BIT]
                    & clk_ctrl_reg[sd_clock_pkg::CLK_CARD_EN_BIT];

  // Card clock generator
  card_clock_divider u_divider (
    .clk            (clk),
    .rst_n          (rst_n),
    .run            (card_run),
    .divisor_sel    (clk_ctrl_reg[sd_clock_pkg::CLK_DIV_MSB:sd_clock_pkg::CLK_DIV_LSB]),
    .frac_n         (frac_reg[sd_clock_pkg::FRAC_N_MSB:sd_clock_pkg::FRAC_N_LSB]),
    .frac_m         (frac_reg[sd_clock_pkg::FRAC_M_MSB:sd_clock_pkg::FRAC_M_LSB]),
    .multiplier     (pll_multiplier),
    .card_clock_out (card_clock_out)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Pin drivers and dma gate
  dma_gate_a: assert property (!misc_reg[sd_clock_pkg::MISC_DMA_EN_BIT] |=> !dma_request_out) // [RULE4]
    else $error("dma request passed while gated");
  dma_pass_a: assert property (powered && misc_reg[sd_clock_pkg::MISC_DMA_EN_BIT] // [RULE4]
    |=> dma_request_out == $past(dma_request_in)) else $error("dma request not passed");
  int_open_drain_a: assert property (powered && !misc_reg[sd_clock_pkg::MISC_INT_MODE_BIT] // [RULE3]
    |=> !int_out && (int_oe == $past(int_request))) else $error("open-drain drive wrong");
  int_push_pull_a: assert property (powered && misc_reg[sd_clock_pkg::MISC_INT_MODE_BIT] // [RULE3]
    |=> int_oe && (int_out == !$past(int_request))) else $error("push-pull drive wrong");

  // Power-off and full reset
  coma_enter_a: assert property (write_ok // [RULE5]
    && hit(pin_sync_reg.addr, sd_clock_pkg::MISC_OFS)
    && pin_sync_reg.data[sd_clock_pkg::MISC_COMA_BIT] |=> !powered)
    else $error("coma bit did not power off");
  coma_quiet_a: assert property (!powered |-> !data_oe ##1 (!int_oe && !dma_request_out // [RULE5]
    && pll_reg == sd_clock_pkg::PLL_RESET)) else $error("activity while powered off");
  card_stop_a: assert property (!card_run |=> !card_clock_out) // [RULE5]
    else $error("card clock ran while stopped");
  coma_exit_a: assert property (!powered && soft_reset_hit |=> powered // [RULE6]
    && misc_reg == sd_clock_pkg::MISC_RESET) else $error("full reset did not wake device");
  soft_reset_a: assert property (soft_reset_hit |=> // [RULE6]
    pll_reg == sd_clock_pkg::PLL_RESET && frac_reg == sd_clock_pkg::FRAC_RESET
    && clk_ctrl_reg == sd_clock_pkg::CLK_CTRL_RESET) else $error("full reset left registers set");

  // PLL settings
  pll_default_a: assert property (pll_reg == sd_clock_pkg::PLL_RESET // [RULE7]
    |=> pll_multiplier == 6'h05) else $error("default multiplier not five");
  pll_mult_a: assert property (!pll_reg[sd_clock_pkg::PLL_BYP_ALL_BIT] |=> // [RULE8]
    pll_multiplier == {1'b0, $past(pll_reg[4:0])} + 6'h01) else $error("multiplier not B+1");
  post_bypass_a: assert property (pll_reg[sd_clock_pkg::PLL_BYP_POST_BIT] // [RULE11]
    |=> pll_post_div == sd_clock_pkg::POST_BYPASS_P)
    else $error("post divider bypass not applied");
  pll_bypass_a: assert property (pll_reg[sd_clock_pkg::PLL_BYP_POST_BIT] // [RULE11]
    && pll_reg[sd_clock_pkg::PLL_BYP_ALL_BIT] |=> pll_post_div == 2'h1 && pll_multiplier == 6'h01)
    else $error("bypass not applied");

  // Register fields and readback
  frac_fields_a: assert property (write_ok && hit(pin_sync_reg.addr, sd_clock_pkg::FRAC_OFS) // [RULE2]
    |=> frac_reg == {4'h0, $past(pin_sync_reg.data[11:0])}) else $error("fraction fields wrong");
  frac_reserved_a: assert property (frac_reg[15:12] == 4'h0) // [RULE2]
    else $error("reserved fraction bits set");
  revision_read_a: assert property (read_active && hit(pin_sync_reg.addr, sd_clock_pkg::REV_OFS) // [RULE12]
    |=> data_out == {REVISION_CODE, 8'h00}) else $error("revision readback wrong");

  // Main scenarios reached
  coma_enter_c: cover property (powered ##1 !powered);
  coma_leave_c: cover property (!powered ##1 powered);
  card_clock_c: cover property ($rose(card_clock_out) ##[1:40] $fell(card_clock_out));
  rev_read_c:   cover property (read_active && hit(pin_sync_reg.addr, sd_clock_pkg::REV_OFS));
  full_reset_c: cover property (!powered && soft_reset_hit);

endmodule : sd_clock_power_ctrl
`default_nettype wire

// ---- host_model.sv ----
// Host processor model that drives the asynchronous register port of the clock block.
// Assumes the bench calls its tasks from one process and that clk is the shared reference.
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic        clk,
  output logic             cs_b,
  output logic             rd_b,
  output logic             wr_b,
  output logic      [7:0]  addr,
  output logic      [15:0] data_in,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe
);
  // Idle port at time zero
  initial begin
    cs_b    = 1'b1;
    rd_b    = 1'b1;
    wr_b    = 1'b1;
    addr    = 8'h00;
    data_in = 16'h0000;
  end

  // Word write: strobes held five cycles, then a gap of four
  task automatic write_word(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    cs_b    <= 1'b0;
    wr_b    <= 1'b0;
    addr    <= a;
    data_in <= d;
    repeat (5) @(posedge clk);
    cs_b    <= 1'b1;
    wr_b    <= 1'b1;
    data_in <= ~d; // Released bus never repeats the last word
    repeat (4) @(posedge clk);
  endtask : write_word

  // Word read: data taken once the enable has been up for several cycles
  task automatic read_word(input logic [7:0] a, output logic oe, output logic [15:0] d);
    @(posedge clk);
    cs_b <= 1'b0;
    rd_b <= 1'b0;
    addr <= a;
    repeat (5) @(posedge clk);
    @(negedge clk);
    oe = data_oe;
    d  = data_out;
    @(posedge clk);
    cs_b <= 1'b1;
    rd_b <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : read_word
endmodule : host_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the card clock, PLL setting and power control block.
// Assumes the host model speaks the port protocol and the default revision code.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk;
  logic        rst_b;
  logic        cs_b, rd_b, wr_b;
  logic [7:0]  addr;
  logic [15:0] data_in, data_out, rd;
  logic        data_oe, int_request, int_out, int_oe, oe, prev;
  logic        dma_request_in, dma_request_out, card_clock_out;
  logic [5:0]  pll_multiplier;
  logic [1:0]  pll_post_div;
  logic        pll_bypassed, core_power_on;
  int          errors, checks_done, i, cnt, ex, mult, dv;
  logic [15:0] plls [4] = '{16'h0060, 16'h0041, 16'h0060, 16'h0021}; // Legal post settings
  logic [15:0] fracs [4] = '{16'h0002, 16'h0803, 16'h0004, 16'h0803};
  logic [15:0] ctls [4] = '{16'h0205, 16'h0105, 16'h0005, 16'h0105};

  host_model host (.clk(clk), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  sd_clock_power_ctrl dut (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .int_request(int_request), .int_out(int_out), .int_oe(int_oe),
    .dma_request_in(dma_request_in), .dma_request_out(dma_request_out),
    .card_clock_out(card_clock_out), .pll_multiplier(pll_multiplier),
    .pll_post_div(pll_post_div), .pll_bypassed(pll_bypassed), .core_power_on(core_power_on));

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Verdict and end of run
  task automatic complete_run;
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  // Compare one value
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Read a word and expect the bus driven with the given value
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    host.read_word(a, oe, rd);
    check({15'h0000, oe}, 16'h0001);
    check(rd, exp);
  endtask : rd_chk

  // Set the interrupt request, then check dma, int level and int enable pins
  task automatic pins(input logic req, input logic [2:0] exp);
    @(posedge clk);
    int_request <= req;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({13'h0000, dma_request_out, int_out, int_oe}, {13'h0000, exp});
  endtask : pins

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    errors = 0;
    checks_done = 0;
    rst_b = 1'b0;
    int_request = 1'b0;
    dma_request_in = 1'b1;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(8'hFA, sd_clock_pkg::PLL_RESET);
    check({10'h000, pll_multiplier}, 16'h0005);
    rd_chk(8'hF6, sd_clock_pkg::FRAC_RESET);
    rd_chk(8'hF8, sd_clock_pkg::MISC_RESET);
    rd_chk(8'h2C, sd_clock_pkg::CLK_CTRL_RESET);
    rd_chk(8'h80, 16'h0000);
    host.write_word(8'hFE, 16'hFFFF);
    rd_chk(8'hFE, 16'hA500);
    host.write_word(8'hF6, 16'hFFFF);
    rd_chk(8'hF6, 16'h0FFF);
    // Multiplier, post divider and both bypasses
    host.write_word(8'hFA, 16'h0041);
    check({8'h00, pll_multiplier, pll_post_div}, 16'h000A);
    rd_chk(8'hFA, 16'h0041);
    host.write_word(8'hFA, 16'h4041);
    check({8'h00, pll_multiplier, pll_post_div}, 16'h0009);
    host.write_word(8'hFA, 16'h8041);
    check({7'h00, pll_bypassed, pll_multiplier, pll_post_div}, 16'h0106);
    host.write_word(8'hFA, 16'hC041);
    check({7'h00, pll_bypassed, pll_multiplier, pll_post_div}, 16'h0105);
    // Card clock rate over a table of settings
    for (i = 0; i < 4; i++) begin
      host.write_word(8'hFA, plls[i]);
      host.write_word(8'hF6, fracs[i]);
      host.write_word(8'h2C, ctls[i]);
      repeat (40) @(posedge clk);
      mult = plls[i][4:0] + 1;
      dv = (ctls[i][15:8] == 8'h00) ? 1 : 2 * ctls[i][15:8];
      ex = 96 * 16 * mult / (dv * (16 * fracs[i][7:0] + fracs[i][11:8]));
      cnt = 0;
      @(negedge clk);
      prev = card_clock_out;
      repeat (96) begin
        @(negedge clk);
        if (card_clock_out === 1'b1 && prev === 1'b0) cnt++;
        prev = card_clock_out;
      end
      check({15'h0000, cnt >= ex - 1 && cnt <= ex + 1}, 16'h0001);
    end
    rd_chk(8'h2C, 16'h0107);
    // Interrupt pin mode and dma gating
    pins(1'b0, 3'b100);
    pins(1'b1, 3'b101);
    @(posedge clk);
    dma_request_in <= 1'b0;
    pins(1'b0, 3'b000);
    @(posedge clk);
    dma_request_in <= 1'b1;
    host.write_word(8'hF8, 16'h0006);
    pins(1'b0, 3'b111);
    pins(1'b1, 3'b101);
    host.write_word(8'hF8, 16'h0004);
    pins(1'b0, 3'b011);
    // Power-off left by software full reset
    host.write_word(8'hF8, 16'h0001);
    check({15'h0000, core_power_on}, 16'h0000);
    check({15'h0000, card_clock_out}, 16'h0000);
    host.read_word(8'hFA, oe, rd);
    check({15'h0000, oe}, 16'h0000);
    host.write_word(8'hFA, 16'h0041);
    host.write_word(8'h2E, 16'h0100);
    check({15'h0000, core_power_on}, 16'h0001);
    rd_chk(8'hFA, sd_clock_pkg::PLL_RESET);
    rd_chk(8'hF8, sd_clock_pkg::MISC_RESET);
    // Power-off left by the hard reset pin
    host.write_word(8'hF8, 16'h0001);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    check({15'h0000, core_power_on}, 16'h0001);
    rd_chk(8'hF8, sd_clock_pkg::MISC_RESET);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
